/* i2c_remote_access_config.sv */
// Configuration, bus watchdog and address remapping for the I2C remote access bridge
`timescale 1ns/1ps
// ----------------------------------------
// Summary of operation
// - Writing one to bit 6 clears sequence error
// - Forward sequence error sets read-only bit 7
// - SDA delay 250ns plus 50ns per code
// - Block bit rejects remote local-register writes
// - Remote accesses to local targets still pass
// - Watchdog expires 50us fast, 1s slow
// - SDA high and idle: bus free
// - SDA low and idle: nine SCL clocks
// - Disable bit stops the bus watchdog; a recovery already running still finishes its nine clocks
// - Serializer ID bits 7-1; zero disables access
// - Serializer ID auto-loads on receive lock
// - Hold bit blocks auto-load, keeps written ID
// - Slot stores 7-bit physical address, bit0 reserved
// - Alias-addressed transaction remapped before forwarding
// ----------------------------------------
module i2c_remote_access_config
  import i2c_remote_access_config_pkg::*;
#(
  parameter int NUM_SLOTS    = 3,
  parameter int WD_FAST_CNT  = WD_FAST_CYC,
  parameter int WD_SLOW_CNT  = WD_SLOW_CYC
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  output logic                   irq,
  input  wire logic              fwd_seq_err,
  input  wire link_id_t          link_id,
  output logic                   far_access_en,
  input  wire remote_req_t       remote_req,
  output logic                   remote_reg_wr_ok,
  output logic                   remote_reg_wr_blocked,
  output logic                   remote_pass,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   scl_out,
  output logic                   scl_oe,
  input  wire logic              sda_low_req,
  output logic                   sda_out,
  output logic                   sda_oe,
  output logic                   bus_free,
  input  wire logic [6:0]        target_alias [NUM_SLOTS],
  input  wire logic              addr_valid,
  input  wire addr_byte_t        addr_in,
  output logic                   fwd_valid,
  output addr_byte_t             fwd_addr,
  output logic                   fwd_remapped
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (NUM_SLOTS < 1 || NUM_SLOTS > 3) begin : g_bad_slots
    $error("NUM_SLOTS must be 1 to 3");
  end
  if (WD_FAST_CNT < 1 || WD_SLOW_CNT < 1 || WD_SLOW_CNT >= (1 << 28)) begin : g_bad_wd
    $error("Watchdog counts out of range");
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic       seq_err_reg;
  logic [1:0] sda_dly_reg;
  logic       local_wr_blk_reg;
  logic       wd_fast_reg;
  logic       wd_disable_reg;
  logic [6:0] far_addr_reg;
  logic       hold_far_addr_reg;
  logic [6:0] far_target_reg [NUM_SLOTS];
  logic [3:0] irq_status_reg;
  logic [3:0] irq_mask_reg;
  logic [3:0] irq_event;
  logic       lock_reg;
  logic       wd_free_evt;
  logic       wd_hung_evt;

  logic wr_ctrl;
  logic wr_id;
  logic wr_stat;
  logic wr_mask;
  assign wr_ctrl = reg_wr && reg_addr == BUS_SUPERVISION_CTRL_OFS;
  assign wr_id   = reg_wr && reg_addr == REMOTE_SERIALIZER_ID_OFS;
  assign wr_stat = reg_wr && reg_addr == IRQ_STATUS_OFS;
  assign wr_mask = reg_wr && reg_addr == IRQ_MASK_OFS;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sda_dly_reg      <= CTRL_RESET[SDA_DLY_LSB +: 2];
      local_wr_blk_reg <= CTRL_RESET[LOCAL_WR_BLK_BIT];
      wd_fast_reg      <= CTRL_RESET[WD_FAST_BIT];
      wd_disable_reg   <= CTRL_RESET[WD_DISABLE_BIT];
    end else if (wr_ctrl) begin
      sda_dly_reg      <= reg_wdata[SDA_DLY_LSB +: 2];
      local_wr_blk_reg <= reg_wdata[LOCAL_WR_BLK_BIT];
      wd_fast_reg      <= reg_wdata[WD_FAST_BIT];
      wd_disable_reg   <= reg_wdata[WD_DISABLE_BIT];
    end
  end

  // Set wins over the clear so no error is lost
  always_ff @(posedge clock) begin
    if (!nrst) begin
      seq_err_reg <= CTRL_RESET[SEQ_ERR_BIT];
    end else if (fwd_seq_err) begin
      seq_err_reg <= 1'b1;
    end else if (wr_ctrl && reg_wdata[SEQ_CLR_BIT]) begin
      seq_err_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Serializer ID
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      lock_reg <= 1'b0;
    end else begin
      lock_reg <= link_id.lock;
    end
  end

  // Software write takes priority over a load in the same cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      far_addr_reg      <= MAP_RESET[7:ADDR_LSB];
      hold_far_addr_reg <= MAP_RESET[HOLD_FAR_ADDR_BIT];
    end else if (wr_id) begin
      far_addr_reg      <= reg_wdata[7:ADDR_LSB];
      hold_far_addr_reg <= reg_wdata[HOLD_FAR_ADDR_BIT];
    end else if (link_id.lock && !lock_reg && !hold_far_addr_reg) begin
      far_addr_reg <= link_id.id;
    end
  end

  assign far_access_en = far_addr_reg != 7'h00;

  // ----------------------------------------
  // Target slots
  // ----------------------------------------
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
    always_ff @(posedge clock) begin
      if (!nrst) begin
        far_target_reg[s] <= MAP_RESET[7:ADDR_LSB];
      end else if (reg_wr && reg_addr == FAR_TARGET_MAP_0_OFS + 8'(s)) begin
        far_target_reg[s] <= reg_wdata[7:ADDR_LSB];
      end
    end
  end

  // ----------------------------------------
  // Alias remap
  // ----------------------------------------
  logic       hit;
  logic [6:0] hit_addr;
  always_comb begin
    hit      = 1'b0;
    hit_addr = addr_in.addr;
    for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
      if (addr_in.addr == target_alias[s]) begin
        hit      = 1'b1;
        hit_addr = far_target_reg[s];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      fwd_valid    <= 1'b0;
      fwd_addr     <= '0;
      fwd_remapped <= 1'b0;
    end else begin
      fwd_valid    <= addr_valid;
      fwd_remapped <= addr_valid && hit;
      if (addr_valid) begin
        fwd_addr <= '{addr: hit_addr, rw: addr_in.rw};
      end
    end
  end

  // ----------------------------------------
  // Remote access gate
  // ----------------------------------------
  logic local_wr;
  assign local_wr = remote_req.valid && remote_req.write && remote_req.local_reg;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      remote_reg_wr_ok      <= 1'b0;
      remote_reg_wr_blocked <= 1'b0;
      remote_pass           <= 1'b0;
    end else begin
      remote_reg_wr_ok      <= local_wr && !local_wr_blk_reg;
      remote_reg_wr_blocked <= local_wr && local_wr_blk_reg;
      remote_pass           <= remote_req.valid && !remote_req.local_reg;
    end
  end

  // ----------------------------------------
  // SDA output delay
  // ----------------------------------------
  localparam int DLY_W = 8;
  logic [DLY_W-1:0] dly_cnt_reg;
  logic [DLY_W-1:0] dly_cyc;
  logic             sda_pend_reg;

  // Least delay, rounded up to whole cycles
  always_comb begin
    dly_cyc = DLY_W'((SDA_BASE_NS + int'(sda_dly_reg) * SDA_STEP_NS + CLK_NS - 1) / CLK_NS);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sda_pend_reg <= 1'b0;
      dly_cnt_reg  <= '0;
      sda_oe       <= 1'b0;
    end else if (sda_low_req != sda_pend_reg) begin
      sda_pend_reg <= sda_low_req;
      dly_cnt_reg  <= dly_cyc - DLY_W'(1);
    end else if (dly_cnt_reg != '0) begin
      dly_cnt_reg <= dly_cnt_reg - DLY_W'(1);
    end else begin
      sda_oe <= sda_pend_reg;
    end
  end

  assign sda_out = 1'b0;

  // ----------------------------------------
  // Bus watchdog
  // ----------------------------------------
  typedef enum logic [2:0] {
    WD_WATCH = 3'b001,
    WD_LOW   = 3'b010,
    WD_HIGH  = 3'b100
  } wd_state_t;

  wd_state_t   wd_state_reg;
  logic [27:0] idle_cnt_reg;
  logic [27:0] wd_limit;
  logic [11:0] half_cnt_reg;
  logic [3:0]  pulse_cnt_reg;
  logic        scl_d_reg;
  logic        sda_d_reg;
  logic        activity;

  assign wd_limit = wd_fast_reg ? 28'(WD_FAST_CNT) : 28'(WD_SLOW_CNT);
  assign activity = scl_in != scl_d_reg || sda_in != sda_d_reg;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_in;
      sda_d_reg <= sda_in;
    end
  end

  // Free is reported once per idle stretch, not repeatedly
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wd_state_reg  <= WD_WATCH;
      idle_cnt_reg  <= '0;
      half_cnt_reg  <= '0;
      pulse_cnt_reg <= '0;
      wd_free_evt   <= 1'b0;
      wd_hung_evt   <= 1'b0;
      bus_free      <= 1'b0;
    end else begin
      wd_free_evt <= 1'b0;
      wd_hung_evt <= 1'b0;
      case (wd_state_reg)
        WD_WATCH: begin
          if (wd_disable_reg || activity) begin
            idle_cnt_reg <= '0;
            bus_free     <= 1'b0;
          end else if (idle_cnt_reg >= wd_limit - 28'h0000001) begin
            idle_cnt_reg <= '0;
            if (sda_in) begin
              wd_free_evt <= !bus_free;
              bus_free    <= 1'b1;
            end else begin
              wd_hung_evt   <= 1'b1;
              wd_state_reg  <= WD_LOW;
              half_cnt_reg  <= '0;
              pulse_cnt_reg <= '0;
            end
          end else begin
            idle_cnt_reg <= idle_cnt_reg + 28'h0000001;
          end
        end
        WD_LOW: begin
          if (half_cnt_reg == 12'(REC_HALF_CYC - 1)) begin
            half_cnt_reg <= '0;
            wd_state_reg <= WD_HIGH;
          end else begin
            half_cnt_reg <= half_cnt_reg + 12'h001;
          end
        end
        WD_HIGH: begin
          if (half_cnt_reg == 12'(REC_HALF_CYC - 1)) begin
            half_cnt_reg <= '0;
            if (pulse_cnt_reg == 4'(REC_PULSES - 1)) begin
              wd_state_reg <= WD_WATCH;
            end else begin
              pulse_cnt_reg <= pulse_cnt_reg + 4'h1;
              wd_state_reg  <= WD_LOW;
            end
          end else begin
            half_cnt_reg <= half_cnt_reg + 12'h001;
          end
        end
        default: begin
          wd_state_reg <= WD_WATCH;
        end
      endcase
    end
  end

  assign scl_out = 1'b0;
  assign scl_oe  = wd_state_reg == WD_LOW;

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign irq_event = {remote_reg_wr_blocked, wd_hung_evt, wd_free_evt, fwd_seq_err};

  always_ff @(posedge clock) begin
    if (!nrst) begin
      irq_status_reg <= IRQ_RESET;
    end else begin
      irq_status_reg <= (irq_status_reg & ~(wr_stat ? reg_wdata[3:0] : 4'h0)) | irq_event;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      irq_mask_reg <= IRQ_RESET;
    end else if (wr_mask) begin
      irq_mask_reg <= reg_wdata[3:0];
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      BUS_SUPERVISION_CTRL_OFS: rd_mux = {seq_err_reg, 2'b00, sda_dly_reg, local_wr_blk_reg,
                                          wd_fast_reg, wd_disable_reg};
      REMOTE_SERIALIZER_ID_OFS: rd_mux = {far_addr_reg, hold_far_addr_reg};
      IRQ_STATUS_OFS:           rd_mux = {4'h0, irq_status_reg};
      IRQ_MASK_OFS:             rd_mux = {4'h0, irq_mask_reg};
      default: begin
        for (int s = 0; s < NUM_SLOTS; s++) begin
          if (reg_addr == FAR_TARGET_MAP_0_OFS + 8'(s)) begin
            rd_mux = {far_target_reg[s], 1'b0};
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

/* i2c_remote_access_config_assertions.sv */
// Port checker for the I2C remote access configuration block
`timescale 1ns/1ps
module remote_access_checker
  import i2c_remote_access_config_pkg::*;
#(
  parameter int NUM_SLOTS   = 3,
  parameter int WD_FAST_CNT = 20,
  parameter int WD_SLOW_CNT = 40
) (
  input wire logic        clock,
  input wire logic        nrst,
  input wire remote_req_t remote_req,
  input wire logic        remote_reg_wr_ok,
  input wire logic        remote_reg_wr_blocked,
  input wire logic        remote_pass,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        sda_low_req,
  input wire logic        sda_in,
  input wire logic        bus_free,
  input wire logic        addr_valid,
  input wire addr_byte_t  addr_in,
  input wire logic        fwd_valid,
  input wire addr_byte_t  fwd_addr,
  input wire logic        fwd_remapped
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Run counters, too long for repetition
  // ----------------------------------------
  logic [11:0] hi_cnt;
  logic [7:0]  st_cnt;
  logic        req_q;
  always_ff @(posedge clock) begin
    if (!nrst || !scl_oe) begin
      hi_cnt <= 12'h000;
    end else begin
      hi_cnt <= hi_cnt + 12'h001;
    end
  end
  always_ff @(posedge clock) begin
    req_q <= sda_low_req;
    if (!nrst || sda_low_req != req_q) begin
      st_cnt <= 8'h00;
    end else if (st_cnt != 8'hFF) begin
      st_cnt <= st_cnt + 8'h01;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_block_one_answer: assert property (remote_req.valid && remote_req.write && remote_req.local_reg
    |=> remote_reg_wr_ok ^ remote_reg_wr_blocked) else $error("local write answer wrong");
  a_local_passes: assert property (remote_req.valid && !remote_req.local_reg
    |=> remote_pass && !remote_reg_wr_blocked) else $error("local target request not passed");
  a_fwd_follows: assert property (addr_valid |=> fwd_valid ##1 !fwd_valid || $past(addr_valid))
    else $error("forwarded pulse wrong");
  a_rw_kept: assert property (addr_valid |=> fwd_addr.rw == $past(addr_in.rw))
    else $error("read write bit changed");
  a_nomatch_same: assert property (addr_valid ##1 !fwd_remapped |-> fwd_addr.addr == $past(addr_in.addr))
    else $error("unmatched address altered");
  a_lines_low: assert property (!scl_out && !sda_out) else $error("driven level not low");
  a_pulse_width: assert property ($fell(scl_oe) |-> hi_cnt == 12'(REC_HALF_CYC))
    else $error("recovery pulse width wrong");
  a_sda_delay: assert property ($changed(sda_oe) |-> st_cnt >= 8'(SDA_BASE_NS / CLK_NS) && sda_oe == sda_low_req)
    else $error("sda output delay too short");
  a_free_high: assert property ($rose(bus_free) |-> $past(sda_in)) else $error("free with sda low");
  c_blocked: cover property (remote_reg_wr_blocked);
  c_remap: cover property (fwd_remapped);
  c_recover: cover property ($fell(scl_oe));
endmodule

bind i2c_remote_access_config remote_access_checker #(
  .NUM_SLOTS(NUM_SLOTS),
  .WD_FAST_CNT(WD_FAST_CNT),
  .WD_SLOW_CNT(WD_SLOW_CNT)
) u_chk (.*);

/* i2c_remote_access_config_bench.sv */
// Self-checking bench for the I2C remote access configuration block
`timescale 1ns/1ps
module i2c_remote_access_config_bench;
  import i2c_remote_access_config_pkg::*;
  localparam int WDF = 20;
  logic        clock = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic        irq, far_access_en, remote_reg_wr_ok, remote_reg_wr_blocked, remote_pass;
  logic        fwd_seq_err, scl_out, scl_oe, sda_out, sda_oe, bus_free, fwd_valid, fwd_remapped;
  logic        scl_drv = 1'h1, sda_drv = 1'h1, sda_low_req = 1'h0, addr_valid = 1'h0;
  wire logic   scl_in, sda_in;
  link_id_t    link_id;
  remote_req_t remote_req;
  addr_byte_t  addr_in = 8'h00, fwd_addr;
  logic [6:0]  target_alias [3] = '{7'h30, 7'h31, 7'h32};
  int          err_total = 0, checks = 0;
  always #2 clock = ~clock;
  // Open-drain lines: any pull wins
  assign scl_in = scl_drv & ~scl_oe;
  assign sda_in = sda_drv & ~sda_oe;
  i2c_remote_access_config #(.WD_FAST_CNT(WDF), .WD_SLOW_CNT(40)) i_i2c_remote_access_config (.*);
  far_serializer_model i_far_serializer_model (.*);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task automatic idle_to_free(input int lim);
    int n = 0;
    @(posedge clock);
    scl_drv <= 1'h0;
    @(posedge clock);
    scl_drv <= 1'h1;
    do begin
      @(posedge clock);
      #1 n++;
    end while (n < 300 && !(n > 4 && bus_free === 1'h1));
    check("free_time", 16'(n >= lim && n <= lim + 6), 16'h1);
  endtask
  task automatic wait_scl(input logic v, inout int n);
    do begin
      @(posedge clock);
      #1 n++;
    end while (scl_oe !== v && n < 3000);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [7:0] d;
    for (int i = 6; i <= 10; i++) begin
      rd(8'(i), d);
      check("reset_val", d, 8'h00);
    end
    wr(8'h08, 8'hA5);
    rd(8'h08, d);
    check("slot_rsv", d, 8'hA4);
    wr(8'h06, 8'h64);
    rd(8'h06, d);
    check("ctrl_rd", d, 8'h04);
    wr(8'h06, 8'h00);
    wr(8'h3F, 8'hFF);
    rd(8'h3F, d);
    check("unmapped", d, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_seq();
    logic [7:0] d;
    i_far_serializer_model.seq_err();
    wr(8'h11, 8'h01);
    rd(8'h06, d);
    check("seq_err", d, 8'h80);
    check("irq_on", irq, 1'h1);
    wr(8'h06, 8'h40);
    rd(8'h06, d);
    check("seq_clr", d, 8'h00);
    wr(8'h10, 8'h01);
    rd(8'h10, d);
    check("irq_clr", {d[0], irq}, 2'h0);
    $display("t_seq done");
  endtask
  task automatic t_block();
    logic [7:0] d;
    wr(8'h06, 8'h04);
    i_far_serializer_model.req(1'h1, 1'h1);
    #1 check("blocked", {remote_reg_wr_blocked, remote_reg_wr_ok}, 2'h2);
    i_far_serializer_model.req(1'h1, 1'h0);
    #1 check("passed", remote_pass, 1'h1);
    rd(8'h10, d);
    check("blk_status", d[3], 1'h1);
    wr(8'h06, 8'h00);
    i_far_serializer_model.req(1'h1, 1'h1);
    #1 check("allowed", {remote_reg_wr_blocked, remote_reg_wr_ok}, 2'h1);
    $display("t_block done");
  endtask
  task automatic t_id();
    logic [7:0] d;
    i_far_serializer_model.lock(7'h2A, 1'h1);
    repeat (4) @(posedge clock);
    rd(8'h07, d);
    check("auto_id", d, 8'h54);
    check("far_en", far_access_en, 1'h1);
    wr(8'h07, 8'h00);
    #1 check("far_off", far_access_en, 1'h0);
    wr(8'h07, 8'h23);
    i_far_serializer_model.lock(7'h2A, 1'h0);
    i_far_serializer_model.lock(7'h2A, 1'h1);
    repeat (4) @(posedge clock);
    rd(8'h07, d);
    check("held_id", d, 8'h23);
    $display("t_id done");
  endtask
  task automatic t_remap();
    logic [6:0] ain [4] = '{7'h30, 7'h31, 7'h32, 7'h12};
    logic [6:0] ph [4] = '{7'h50, 7'h59, 7'h07, 7'h12};
    wr(8'h08, 8'hA0);
    wr(8'h09, 8'hB2);
    wr(8'h0A, 8'h0E);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      addr_valid <= 1'h1;
      addr_in <= {ain[i], i[0]};
      @(posedge clock);
      addr_valid <= 1'h0;
      #1 check("fwd_addr", {fwd_valid, fwd_addr}, {1'h1, ph[i], i[0]});
      check("remapped", fwd_remapped, 1'(i < 3));
    end
    $display("t_remap done");
  endtask
  task automatic t_delay();
    int n;
    for (int c = 0; c < 4; c++) begin
      wr(8'h06, 8'h01 | 8'(c << 3));
      @(posedge clock);
      sda_low_req <= 1'h1;
      n = 0;
      do begin
        @(posedge clock);
        #1 n++;
      end while (sda_oe !== 1'h1 && n < 200);
      check("sda_dly", 16'(n >= (250 + 50 * c) / 4 && n <= (250 + 50 * c) / 4 + 4), 16'h1);
      @(posedge clock);
      sda_low_req <= 1'h0;
      repeat (120) @(posedge clock);
    end
    $display("t_delay done");
  endtask
  task automatic t_wd();
    logic [7:0] d;
    int n = 0;
    wr(8'h06, 8'h02);
    idle_to_free(WDF);
    wr(8'h06, 8'h00);
    idle_to_free(40);
    wr(8'h06, 8'h02);
    @(posedge clock);
    sda_drv <= 1'h0;
    wait_scl(1'h1, n);
    check("hung_start", 16'(n <= WDF + 10), 16'h1);
    for (int k = 0; k < 9; k++) begin
      n = 0;
      wait_scl(1'h0, n);
      if (k < 8) begin
        wait_scl(1'h1, n);
      end
      check("pulse_len", 16'(n), k < 8 ? 16'(2 * REC_HALF_CYC) : 16'(REC_HALF_CYC));
    end
    // Disable before the watcher restarts; a tenth pulse would be a fault
    wr(8'h06, 8'h03);
    n = 0;
    wait_scl(1'h1, n);
    check("no_tenth", scl_oe, 1'h0);
    rd(8'h10, d);
    check("hung_irq", d[2], 1'h1);
    $display("t_wd done");
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'h1;
    t_regs();
    t_seq();
    t_block();
    t_id();
    t_remap();
    t_delay();
    t_wd();
    complete_run();
  end
  // Tests need about 25000 cycles; the 60000-cycle limit means a hang
  initial begin
    #240000;
    err_total++;
    complete_run();
  end
endmodule

/* i2c_remote_access_config_partner.sv */
// Behavioural model of the far serializer link
`timescale 1ns/1ps
module far_serializer_model
  import i2c_remote_access_config_pkg::*;
(
  input wire logic clock,
  output link_id_t    link_id,
  output remote_req_t remote_req,
  output logic        fwd_seq_err
);
  initial begin
    link_id = '0;
    remote_req = '0;
    fwd_seq_err = 1'h0;
  end
  // Lock level carries the ID the device should pick up
  task automatic lock(input logic [6:0] id, input logic on);
    @(posedge clock);
    link_id <= {on, id};
  endtask
  task automatic req(input logic wr, input logic loc);
    @(posedge clock);
    remote_req <= {1'h1, wr, loc};
    @(posedge clock);
    remote_req <= '0;
  endtask
  task automatic seq_err();
    @(posedge clock);
    fwd_seq_err <= 1'h1;
    @(posedge clock);
    fwd_seq_err <= 1'h0;
  endtask
endmodule

/* i2c_remote_access_config_pkg.sv */
// Package of constants and types for the I2C remote access configuration block
package i2c_remote_access_config_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] BUS_SUPERVISION_CTRL_OFS = 8'h06;
  localparam logic [7:0] REMOTE_SERIALIZER_ID_OFS = 8'h07;
  localparam logic [7:0] FAR_TARGET_MAP_0_OFS     = 8'h08;
  localparam logic [7:0] FAR_TARGET_MAP_1_OFS     = 8'h09;
  localparam logic [7:0] FAR_TARGET_MAP_2_OFS     = 8'h0A;
  localparam logic [7:0] IRQ_STATUS_OFS           = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS             = 8'h11;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int SEQ_ERR_BIT       = 7;
  localparam int SEQ_CLR_BIT       = 6;
  localparam int SDA_DLY_LSB       = 3;
  localparam int LOCAL_WR_BLK_BIT  = 2;
  localparam int WD_FAST_BIT       = 1;
  localparam int WD_DISABLE_BIT    = 0;
  localparam int HOLD_FAR_ADDR_BIT = 0;
  localparam int ADDR_LSB          = 1;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] MAP_RESET    = 8'h00;
  localparam logic [3:0] IRQ_RESET    = 4'h0;
  localparam int IRQ_SEQ_ERR  = 0;
  localparam int IRQ_BUS_FREE = 1;
  localparam int IRQ_BUS_HUNG = 2;
  localparam int IRQ_WR_BLOCK = 3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS          = 4;
  localparam int SDA_BASE_NS     = 250;
  localparam int SDA_STEP_NS     = 50;
  localparam int WD_FAST_NS      = 50000;
  localparam longint WD_SLOW_NS  = 64'd1000000000;
  localparam int WD_FAST_CYC     = WD_FAST_NS / CLK_NS;
  localparam int WD_SLOW_CYC     = int'(WD_SLOW_NS / CLK_NS);
  localparam int REC_HALF_NS     = 5000;
  localparam int REC_HALF_CYC    = REC_HALF_NS / CLK_NS;
  localparam int REC_PULSES      = 9;

  // ----------------------------------------
  // Carried types
  // ----------------------------------------
  typedef struct packed {
    logic       lock;
    logic [6:0] id;
  } link_id_t;

  typedef struct packed {
    logic [6:0] addr;
    logic       rw;
  } addr_byte_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic local_reg;
  } remote_req_t;

endpackage
